// [tac_conv_model.sv]
`timescale 1ns/1ns

// Converter stand-in: one done pulse for each start, after lat_in extra clocks
module tac_conv_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [3:0] chan_in,
	input wire logic [3:0] lat_in,
	input wire logic clr_in,
	output logic done_out,
	output logic [11:0] data_out
);
	logic busy;
	logic [3:0] wait_cnt;
	logic [7:0] n;
	logic [11:0] val;

	////////////////////////////////////////
	// Sample is the channel in the top nibble plus a running count, so averages are known
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy <= 1'b0;
			wait_cnt <= 4'h0;
			n <= 8'h00;
			val <= 12'h000;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				busy <= 1'b1;
				wait_cnt <= lat_in;
				val <= {chan_in, n};
			end else if (busy && wait_cnt == 4'h0) begin
				busy <= 1'b0;
				done_out <= 1'b1;
				n <= n + 8'h01;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
			// Clear wins over the count so a held clear pins every sample
			if (clr_in) begin
				n <= 8'h00;
			end
		end
	end

	// Outside the done cycle the bus shows the inverse, never a stale match
	assign data_out = done_out ? val : ~val;
endmodule

// [tac_ctrl.sv]
`timescale 1ns/1ns
`include "tac_map.svh"

module tac_ctrl #(
	parameter logic [14:0] LONG_TICKS = `TAC_T_16384
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [11:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [11:0] reg_rdata_out,
	input wire logic acquisition_hold_input_in,
	input wire logic screen_touched_in,
	input wire logic conv_done_in,
	input wire logic [11:0] conv_data_in,
	input wire logic results_read_in,
	output logic conv_start_out,
	output logic [3:0] conv_chan_out,
	output logic single_or_ratiometric_select_out,
	output logic sampling_out,
	output logic result_we_out,
	output logic [3:0] result_chan_out,
	output logic [11:0] result_data_out,
	output logic results_ready_output_n_out,
	output logic touch_request_output_n_out,
	output logic adc_power_out,
	output logic ref_power_out,
	output logic ref_pin_input_out
);

	tac_pkg::tac_regs_s r;
	tac_pkg::tac_regs_s next_r;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Settle delay in ticks for a two-bit code
	function automatic logic [14:0] settle_ticks(input logic [1:0] code);
		case (code)
			2'h0: settle_ticks = `TAC_T_1;
			2'h1: settle_ticks = `TAC_T_256;
			2'h2: settle_ticks = `TAC_T_2048;
			default: settle_ticks = LONG_TICKS;
		endcase
	endfunction
	// Repeat interval in ticks; code 0 never loads the timer
	function automatic logic [14:0] repeat_ticks(input logic [1:0] code);
		case (code)
			2'h1: repeat_ticks = `TAC_T_1024;
			2'h2: repeat_ticks = `TAC_T_2048;
			default: repeat_ticks = LONG_TICKS;
		endcase
	endfunction
	// Sample window in ticks
	function automatic logic [14:0] acq_ticks(input logic [1:0] code);
		case (code)
			2'h0: acq_ticks = `TAC_T_4;
			2'h1: acq_ticks = `TAC_T_8;
			2'h2: acq_ticks = `TAC_T_16;
			default: acq_ticks = `TAC_T_32;
		endcase
	endfunction
	// Conversions per channel
	function automatic logic [4:0] avg_count(input logic [1:0] code);
		case (code)
			2'h0: avg_count = `TAC_AVG_1;
			2'h1: avg_count = `TAC_AVG_4;
			2'h2: avg_count = `TAC_AVG_8;
			default: avg_count = `TAC_AVG_16;
		endcase
	endfunction
	// Lowest masked channel at or above 'from'; bit 4 says one was found
	function automatic logic [4:0] next_ch(input logic [11:0] m, input logic [3:0] from);
		logic [4:0] res;
		res = 5'h00;
		for (int i = `TAC_CH_MAX; i >= 0; i--) begin
			if (m[`TAC_MASK_TOP - i] && 4'(i) >= from) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Decoded fields

	logic [1:0] mode;
	logic [1:0] pm;
	logic [11:0] seq_mask;
	logic hold_act;
	logic tick;
	logic busy;
	logic run_ok;
	logic [15:0] avg_val;
	logic [15:0] acc_sum;
	// The host may rewrite the mode at any time; run_ok gates every state
	assign mode = r.ctrl1[`TAC_C1_MODE];
	assign pm = r.ctrl2[`TAC_C2_PM];
	assign run_ok = (mode != `TAC_MODE_NONE) && (pm != `TAC_PM_OFF);
	assign seq_mask = (mode == `TAC_MODE_MASTER) ? r.mmask : r.smask;
	assign hold_act = r.ctrl2[`TAC_C2_POL] ? r.hold_s2 : !r.hold_s2;
	assign tick = (r.pre == `TAC_PRE_LAST);
	assign busy = (r.st != tac_pkg::TAC_IDLE) && (r.st != tac_pkg::TAC_INTERVAL);
	assign acc_sum = r.acc + {4'h0, conv_data_in};
	// Average takes in the sample arriving now; shift by log2 of the count
	always_comb begin
		case (r.ctrl2[`TAC_C2_AVG])
			2'h0: avg_val = acc_sum;
			2'h1: avg_val = acc_sum >> 2;
			2'h2: avg_val = acc_sum >> 3;
			default: avg_val = acc_sum >> 4;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic [4:0] nx;
		logic go_start;
		logic seq_end;
		nx = 5'h00;
		go_start = 1'b0;
		seq_end = 1'b0;
		next_r = r;
		next_r.start = 1'b0;
		next_r.we = 1'b0;
		next_r.rdata = `TAC_REG_RESET;
		// Pins are foreign to this clock; second stage is the only reader of the first
		next_r.hold_s1 = acquisition_hold_input_in;
		next_r.hold_s2 = r.hold_s1;
		next_r.touch_s1 = screen_touched_in;
		next_r.touch_s2 = r.touch_s1;
		next_r.pre = tick ? 4'h0 : r.pre + 4'h1;
		if (!r.touch_s2) begin
			next_r.need_release = 1'b0;
		end
		// Sequencer
		case (r.st)
			tac_pkg::TAC_IDLE: begin
				if (run_ok) begin
					if (mode != `TAC_MODE_MASTER) begin
						go_start = 1'b1;
					end else if (r.touch_s2 && !r.need_release) begin
						go_start = 1'b1;
					end
				end
			end
			tac_pkg::TAC_SETTLE: begin
				// Hold input is not looked at here, so it cannot stretch the delay
				if (tick) begin
					next_r.cnt = r.cnt - 15'h0001;
					if (r.cnt == `TAC_T_1) begin
						next_r.st = tac_pkg::TAC_ACQ;
						next_r.cnt = acq_ticks(r.ctrl2[`TAC_C2_ACQ]);
					end
				end
			end
			tac_pkg::TAC_ACQ: begin
				// Window freezes while the hold input is active to dodge display noise
				if (tick && !hold_act) begin
					next_r.cnt = r.cnt - 15'h0001;
					if (r.cnt == `TAC_T_1) begin
						next_r.st = tac_pkg::TAC_CONV;
						next_r.start = 1'b1;
					end
				end
			end
			tac_pkg::TAC_CONV: begin
				if (conv_done_in) begin
					next_r.acc = r.acc + {4'h0, conv_data_in};
					next_r.avg_left = r.avg_left - 5'h01;
					if (r.avg_left != 5'h01) begin
						next_r.st = tac_pkg::TAC_ACQ;
						next_r.cnt = acq_ticks(r.ctrl2[`TAC_C2_ACQ]);
					end else begin
						next_r.we = 1'b1;
						next_r.res_ch = r.ch;
						next_r.res_data = 12'(avg_val);
						next_r.wrote = 1'b1;
						next_r.acc = 16'h0000;
						next_r.avg_left = avg_count(r.ctrl2[`TAC_C2_AVG]);
						if (mode != `TAC_MODE_SINGLE) begin
							nx = next_ch(seq_mask, r.ch + 4'h1);
						end
						if (nx[4]) begin
							next_r.ch = nx[3:0];
							if (nx[3:0] <= `TAC_CH_XY) begin
								next_r.st = tac_pkg::TAC_SETTLE;
								next_r.cnt = settle_ticks(r.ctrl2[`TAC_C2_FCD]);
							end else begin
								next_r.st = tac_pkg::TAC_ACQ;
								next_r.cnt = acq_ticks(r.ctrl2[`TAC_C2_ACQ]);
							end
						end else begin
							next_r.st = tac_pkg::TAC_TAIL;
							next_r.cnt = settle_ticks(r.ctrl2[`TAC_C2_FCD]);
						end
					end
				end
			end
			tac_pkg::TAC_TAIL: begin
				if (tick) begin
					next_r.cnt = r.cnt - 15'h0001;
					if (r.cnt == `TAC_T_1) begin
						seq_end = 1'b1;
					end
				end
			end
			tac_pkg::TAC_INTERVAL: begin
				if (mode == `TAC_MODE_MASTER && !r.touch_s2) begin
					next_r.st = tac_pkg::TAC_IDLE;
				end else if (tick) begin
					next_r.cnt = r.cnt - 15'h0001;
					if (r.cnt == `TAC_T_1) begin
						next_r.dav_n = 1'b1;
						go_start = 1'b1;
					end
				end
			end
			default: begin
				next_r.st = tac_pkg::TAC_IDLE;
			end
		endcase
		// End of a sequence: flag results, then repeat, wait or stop
		if (seq_end) begin
			if (r.wrote) begin
				next_r.dav_n = 1'b0;
			end
			if (r.ctrl2[`TAC_C2_TMR] == 2'h0) begin
				next_r.st = tac_pkg::TAC_IDLE;
				if (mode == `TAC_MODE_MASTER) begin
					next_r.need_release = 1'b1;
				end else begin
					next_r.ctrl1[`TAC_C1_MODE] = `TAC_MODE_NONE;
				end
			end else if (mode == `TAC_MODE_MASTER && !r.touch_s2) begin
				next_r.st = tac_pkg::TAC_IDLE;
			end else begin
				next_r.st = tac_pkg::TAC_INTERVAL;
				next_r.cnt = repeat_ticks(r.ctrl2[`TAC_C2_TMR]);
			end
		end
		// Start of a run with a valid channel begins with the settle delay, which covers power-up
		if (go_start) begin
			next_r.st = tac_pkg::TAC_SETTLE;
			next_r.cnt = settle_ticks(r.ctrl2[`TAC_C2_FCD]);
			next_r.wrote = 1'b0;
			next_r.acc = 16'h0000;
			next_r.avg_left = avg_count(r.ctrl2[`TAC_C2_AVG]);
			next_r.ratio = r.ctrl1[`TAC_C1_RATIO];
			if (mode == `TAC_MODE_SINGLE) begin
				next_r.ch = r.ctrl1[`TAC_C1_CH];
				nx = {(r.ctrl1[`TAC_C1_CH] <= 4'(`TAC_CH_MAX)), r.ctrl1[`TAC_C1_CH]};
			end else begin
				nx = next_ch(seq_mask, 4'h0);
				next_r.ch = nx[3:0];
			end
			// Invalid code or empty mask: no conversion, only the closing delay
			if (!nx[4]) begin
				next_r.st = tac_pkg::TAC_TAIL;
			end
		end
		// Mode 00 or power-off stops any run at once
		if (!run_ok && r.st != tac_pkg::TAC_IDLE) begin
			next_r.st = tac_pkg::TAC_IDLE;
		end
		// Host read of the results clears the ready flag unless new results land now
		if (results_read_in && !(seq_end && r.wrote)) begin
			next_r.dav_n = 1'b1;
		end
		// Touch request held during a run, follows the screen in IDLE and INTERVAL
		if (!busy) begin
			next_r.pen_n = !r.touch_s2;
		end
		// Power and reference controls
		next_r.adc_pw = (pm == `TAC_PM_ON) || (pm[0] && busy);
		next_r.ref_pw = !r.ctrl2[`TAC_C2_REF] && ((pm == `TAC_PM_ON)
			|| (pm == `TAC_PM_ADC_ONLY) || (pm[0] && busy));
		next_r.ref_in = r.ctrl2[`TAC_C2_REF];
		next_r.samp = (next_r.st == tac_pkg::TAC_ACQ); // Registered copy of the sample state
		// Register writes; a host write of the mode overrides the hardware clear
		if (reg_wr_in) begin
			case (reg_addr_in)
				`TAC_A_CTRL1: begin
					next_r.ctrl1 = reg_wdata_in;
					next_r.need_release = 1'b0;
				end
				`TAC_A_CTRL2: next_r.ctrl2 = reg_wdata_in;
				`TAC_A_SMASK: next_r.smask = reg_wdata_in;
				`TAC_A_MMASK: next_r.mmask = reg_wdata_in;
				default: ;
			endcase
		end
		// Register reads, answered in the next cycle only
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TAC_A_CTRL1: next_r.rdata = r.ctrl1;
				`TAC_A_CTRL2: next_r.rdata = r.ctrl2;
				`TAC_A_SMASK: next_r.rdata = r.smask;
				`TAC_A_MMASK: next_r.rdata = r.mmask;
				`TAC_A_STAT: next_r.rdata = {r.dav_n, r.pen_n, r.adc_pw, r.ref_pw, 1'b0, r.st, r.ch};
				default: next_r.rdata = `TAC_REG_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
			r.dav_n <= 1'b1;
			r.pen_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs come straight from the state register
	assign reg_rdata_out = r.rdata;
	assign conv_start_out = r.start;
	assign conv_chan_out = r.ch;
	assign single_or_ratiometric_select_out = r.ratio;
	assign sampling_out = r.samp;
	assign result_we_out = r.we;
	assign result_chan_out = r.res_ch;
	assign result_data_out = r.res_data;
	assign results_ready_output_n_out = r.dav_n;
	assign touch_request_output_n_out = r.pen_n;
	assign adc_power_out = r.adc_pw;
	assign ref_power_out = r.ref_pw;
	assign ref_pin_input_out = r.ref_in;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_tail_last;
		r.st == tac_pkg::TAC_TAIL && tick && r.cnt == `TAC_T_1 && run_ok;
	endsequence
	sequence s_back_idle_mode_clear;
		r.st == tac_pkg::TAC_IDLE && mode == `TAC_MODE_NONE;
	endsequence
	property p_mode_clear;
		(s_tail_last and (r.ctrl2[`TAC_C2_TMR] == 2'h0 && mode != `TAC_MODE_MASTER
			&& !reg_wr_in)) |=> s_back_idle_mode_clear;
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");
	// A host write may re-enable power right after, so only the next cycle is judged
	property p_pm_off;
		pm == `TAC_PM_OFF |=> !adc_power_out && r.st == tac_pkg::TAC_IDLE;
	endproperty
	a_pm_off: assert property (p_pm_off) else $error("converter powered while off");
	property p_ext_ref;
		r.ctrl2[`TAC_C2_REF] |=> !ref_power_out && ref_pin_input_out;
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("internal reference on");
	property p_hold_freeze;
		(r.st == tac_pkg::TAC_ACQ && hold_act && run_ok) |=> $stable(r.cnt);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("sampled while held");
	property p_settle_ignores_hold;
		(r.st == tac_pkg::TAC_SETTLE && tick && r.cnt > `TAC_T_1 && run_ok)
			|=> r.cnt == $past(r.cnt) - 15'h0001;
	endproperty
	a_settle_ignores_hold: assert property (p_settle_ignores_hold) else $error("settle stalled");
	property p_acq_len;
		(r.st == tac_pkg::TAC_ACQ && $past(r.st) != tac_pkg::TAC_ACQ)
			|-> r.cnt == acq_ticks($past(r.ctrl2[`TAC_C2_ACQ]));
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("wrong sample window");
	property p_valid_chan;
		conv_start_out |-> conv_chan_out <= 4'(`TAC_CH_MAX);
	endproperty
	a_valid_chan: assert property (p_valid_chan) else $error("invalid channel converted");
	property p_avg_hold;
		(r.st == tac_pkg::TAC_CONV && conv_done_in && r.avg_left != 5'h01) |=> !result_we_out;
	endproperty
	a_avg_hold: assert property (p_avg_hold) else $error("partial average written");
	property p_release_stops;
		(r.st == tac_pkg::TAC_INTERVAL && mode == `TAC_MODE_MASTER && !r.touch_s2 && run_ok)
			|=> r.st == tac_pkg::TAC_IDLE;
	endproperty
	a_release_stops: assert property (p_release_stops) else $error("timer ran untouched");
	property p_dav_read;
		(!results_ready_output_n_out && results_read_in && r.st != tac_pkg::TAC_TAIL)
			|=> results_ready_output_n_out;
	endproperty
	a_dav_read: assert property (p_dav_read) else $error("ready not cleared");

endmodule

// [tac_map.svh]
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH

// Register indices on the plain register port
`define TAC_A_CTRL1 3'h0
`define TAC_A_CTRL2 3'h1
`define TAC_A_SMASK 3'h2
`define TAC_A_MMASK 3'h3
`define TAC_A_STAT 3'h4
`define TAC_REG_RESET 12'h000

// Channel and mode control fields
`define TAC_C1_RATIO 11
`define TAC_C1_CH 10:7
`define TAC_C1_MODE 1:0
`define TAC_MODE_NONE 2'h0
`define TAC_MODE_SINGLE 2'h1
`define TAC_MODE_SLAVE 2'h2
`define TAC_MODE_MASTER 2'h3
`define TAC_CH_MAX 10
`define TAC_CH_XY 4'h1
`define TAC_MASK_TOP 11

// Setup control fields
`define TAC_C2_TMR 1:0
`define TAC_C2_REF 2
`define TAC_C2_POL 3
`define TAC_C2_FCD 5:4
`define TAC_C2_PM 7:6
`define TAC_C2_ACQ 9:8
`define TAC_C2_AVG 11:10
`define TAC_PM_OFF 2'h0
`define TAC_PM_ON 2'h2
`define TAC_PM_ADC_ONLY 2'h3

// Conversion clock derived from the system clock, rounded up
`define TAC_CONV_NS 500
`define TAC_CLK_NS 40
`define TAC_PRE_LAST 4'((`TAC_CONV_NS + `TAC_CLK_NS - 1) / `TAC_CLK_NS - 1)

// Counts in conversion-clock ticks, then conversions per average
`define TAC_T_1 15'h0001
`define TAC_T_4 15'h0004
`define TAC_T_8 15'h0008
`define TAC_T_16 15'h0010
`define TAC_T_32 15'h0020
`define TAC_T_256 15'h0100
`define TAC_T_1024 15'h0400
`define TAC_T_2048 15'h0800
`define TAC_T_16384 15'h4000
`define TAC_AVG_1 5'h01
`define TAC_AVG_4 5'h04
`define TAC_AVG_8 5'h08
`define TAC_AVG_16 5'h10

`endif

// [tac_pkg.sv]
package tac_pkg;

	typedef enum logic [2:0] {
		TAC_IDLE = 3'b000,
		TAC_SETTLE = 3'b001,
		TAC_ACQ = 3'b010,
		TAC_CONV = 3'b011,
		TAC_TAIL = 3'b100,
		TAC_INTERVAL = 3'b101
	} tac_state_e;

	typedef struct packed {
		logic [11:0] ctrl1;
		logic [11:0] ctrl2;
		logic [11:0] smask;
		logic [11:0] mmask;
		logic [11:0] rdata;
		tac_state_e st;
		logic [3:0] ch;
		logic [3:0] pre;
		logic [14:0] cnt;
		logic [4:0] avg_left;
		logic [15:0] acc;
		logic wrote;
		logic need_release;
		logic hold_s1;
		logic hold_s2;
		logic touch_s1;
		logic touch_s2;
		logic dav_n;
		logic pen_n;
		logic adc_pw;
		logic ref_pw;
		logic ref_in;
		logic start;
		logic ratio;
		logic we;
		logic samp;
		logic [3:0] res_ch;
		logic [11:0] res_data;
	} tac_regs_s;

endpackage

// [testbench.sv]
`timescale 1ns/1ns
`include "tac_map.svh"

module testbench;
	logic clk, rst_n, wr_s, rd_s, hold, touch, done, rres, clr;
	logic cstart, ratio, samp, we, rdy_n, pen_n, adcp, refp, refin;
	logic [2:0] addr;
	logic [11:0] wdata, rdata, cdata, rdat;
	logic [3:0] cchan, rch, lat;
	int n_errors;
	int checked;

	// Code-3 settle and repeat counts shortened to 16 ticks to keep the run short
	tac_ctrl #(.LONG_TICKS(15'h0010)) dut_u (
		.clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.acquisition_hold_input_in(hold), .screen_touched_in(touch),
		.conv_done_in(done), .conv_data_in(cdata), .results_read_in(rres),
		.conv_start_out(cstart), .conv_chan_out(cchan),
		.single_or_ratiometric_select_out(ratio), .sampling_out(samp),
		.result_we_out(we), .result_chan_out(rch), .result_data_out(rdat),
		.results_ready_output_n_out(rdy_n), .touch_request_output_n_out(pen_n),
		.adc_power_out(adcp), .ref_power_out(refp), .ref_pin_input_out(refin)
	);

	tac_conv_model conv_u (
		.clk_in(clk), .rst_n_in(rst_n), .start_in(cstart), .chan_in(cchan),
		.lat_in(lat), .clr_in(clr), .done_out(done), .data_out(cdata)
	);

	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [2:0] a, output logic [11:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic pulse_read();
		@(posedge clk);
		rres <= 1'b1;
		@(posedge clk);
		rres <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// Counts edges until an event shows, or the limit runs out
	task automatic wait_for(input int which, input int lim, output int n);
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < lim) begin
			@(posedge clk);
			#1;
			n++;
			case (which)
				0: hit = (samp === 1'b1);
				1: hit = (rdy_n === 1'b1);
				2: hit = (rdy_n === 1'b0);
				3: hit = (we === 1'b1);
				default: hit = (cstart === 1'b1);
			endcase
		end
	endtask

	task automatic expect_res(input logic [3:0] ch, input logic [11:0] d);
		int n;
		wait_for(3, 12000, n);
		check("result_we", 16'(we), 16'h0001);
		check("result_chan", 16'(rch), 16'(ch));
		check("result_data", 16'(rdat), 16'(d));
	endtask

	////////////////////////////////////////
	task automatic s_regs();
		logic [11:0] v [4] = '{12'h5A4, 12'hF3F, 12'hFFE, 12'h555};
		logic [11:0] d;
		for (int i = 0; i < 4; i++) begin
			rd(3'(i), d);
			check("reset value", 16'(d), 16'h0000);
			wr(3'(i), v[i]);
			rd(3'(i), d);
			check("read back", 16'(d), 16'(v[i]));
		end
		wr(3'h5, 12'hFFF);
		rd(3'h5, d);
		check("unmapped", 16'(d), 16'h0000);
		rd(`TAC_A_STAT, d);
		check("status", 16'(d[11:4]), 16'h00C0);
		for (int i = 0; i < 4; i++) begin
			wr(3'(i), 12'h000);
		end
	endtask

	task automatic s_single();
		logic [11:0] v;
		logic [11:0] d;
		int n;
		wr(`TAC_A_CTRL2, 12'h080);
		for (int i = 0; i < 2; i++) begin
			v = i ? 12'h501 : 12'h981;
			clr <= 1'b1;
			wr(`TAC_A_CTRL1, v);
			clr <= 1'b0;
			wait_for(4, 300, n);
			check("chan", 16'(cchan), i ? 16'h000A : 16'h0003);
			check("ratio", 16'(ratio), i ? 16'h0000 : 16'h0001);
			expect_res(i ? 4'hA : 4'h3, i ? 12'hA00 : 12'h300);
			wait_for(2, 100, n);
			check("ready low", 16'(rdy_n), 16'h0000);
			rd(`TAC_A_CTRL1, d);
			check("mode cleared", 16'(d), 16'(v & 12'hFFC));
			pulse_read();
			check("ready high", 16'(rdy_n), 16'h0001);
		end
	endtask

	task automatic s_invalid();
		logic [11:0] d;
		int n;
		for (int c = 11; c < 16; c++) begin
			wr(`TAC_A_CTRL1, 12'(c << 7) | 12'h001);
			wait_for(3, 400, n);
			check("no result", 16'(we), 16'h0000);
			rd(`TAC_A_CTRL1, d);
			check("mode cleared", 16'(d), 16'(c << 7));
		end
	endtask

	// Window length and averaging together: one run per code
	task automatic s_avg();
		int n;
		int w;
		for (int k = 0; k < 4; k++) begin
			w = 13 * (4 << k);
			wr(`TAC_A_CTRL2, 12'(k << 10 | k << 8) | 12'h080);
			clr <= 1'b1;
			wr(`TAC_A_CTRL1, 12'h301);
			clr <= 1'b0;
			wait_for(0, 300, n);
			wait_for(4, 600, n);
			check("window", 16'(n >= w - 13 && n <= w + 13), 16'h0001);
			expect_res(4'h6, 12'h600 + 12'(((k ? 2 << k : 1) - 1) >> 1));
			wait_for(3, 300, n);
			check("one result", 16'(we), 16'h0000);
			pulse_read();
		end
	endtask

	task automatic s_hold();
		int n;
		for (int p = 0; p < 2; p++) begin
			wr(`TAC_A_CTRL2, 12'h080 | 12'(p << 3));
			hold <= p[0];
			wr(`TAC_A_CTRL1, 12'h201);
			wait_for(4, 300, n);
			check("held", 16'(cstart), 16'h0000);
			@(posedge clk);
			hold <= ~p[0];
			wait_for(2, 300, n);
			check("released", 16'(rdy_n), 16'h0000);
			pulse_read();
		end
		wr(`TAC_A_CTRL2, 12'h080);
		hold <= 1'b1;
	endtask

	task automatic s_settle();
		int t [3] = '{1, 256, 16};
		int c [3] = '{0, 1, 3};
		int n;
		for (int i = 0; i < 3; i++) begin
			wr(`TAC_A_CTRL2, 12'h080 | 12'(c[i] << 4));
			wr(`TAC_A_CTRL1, 12'h181);
			wait_for(0, 5000, n);
			check("settle", 16'(n >= t[i] * 13 - 13 && n <= t[i] * 13 + 30), 16'h0001);
			wait_for(2, 5000, n);
			pulse_read();
		end
	endtask

	task automatic s_power();
		logic [11:0] cv [6] = '{12'h000, 12'h040, 12'h080, 12'h0C0, 12'h084, 12'h0C4};
		logic [2:0] ex [6] = '{3'h0, 3'h0, 3'h6, 3'h2, 3'h5, 3'h1};
		int n;
		for (int i = 0; i < 6; i++) begin
			wr(`TAC_A_CTRL2, cv[i]);
			repeat (3) @(posedge clk);
			#1;
			check("power", 16'({adcp, refp, refin}), 16'(ex[i]));
		end
		wr(`TAC_A_CTRL2, 12'h000);
		wr(`TAC_A_CTRL1, 12'h181);
		wait_for(4, 300, n);
		check("off", 16'(cstart), 16'h0000);
		wr(`TAC_A_CTRL1, 12'h000);
		wr(`TAC_A_CTRL2, 12'h040);
		wr(`TAC_A_CTRL1, 12'h181);
		wait_for(4, 300, n);
		check("powered up", 16'({adcp, refp}), 16'h0003);
		wait_for(2, 300, n);
		// Power flags follow the state register one edge late
		@(posedge clk);
		#1;
		check("idle again", 16'({adcp, refp}), 16'h0000);
		pulse_read();
	endtask

	task automatic s_seq();
		int t [3] = '{1024, 2048, 16};
		int n;
		wr(`TAC_A_CTRL2, 12'h080);
		wr(`TAC_A_SMASK, 12'h802);
		wr(`TAC_A_MMASK, 12'h100);
		clr <= 1'b1;
		wr(`TAC_A_CTRL1, 12'h002);
		clr <= 1'b0;
		expect_res(4'h0, 12'h000);
		expect_res(4'hA, 12'hA01);
		wait_for(2, 100, n);
		check("sequence ready", 16'(rdy_n), 16'h0000);
		pulse_read();
		for (int i = 0; i < 3; i++) begin
			wr(`TAC_A_CTRL2, 12'h080 | 12'(i + 1));
			wr(`TAC_A_CTRL1, 12'h002);
			wait_for(2, 2000, n);
			wait_for(1, 30000, n);
			check("interval", 16'(n > t[i] * 13 - 40 && n < t[i] * 13 + 40), 16'h0001);
			wr(`TAC_A_CTRL1, 12'h000);
			pulse_read();
		end
	endtask

	// Clear held high through the whole run, so every sample reads as 12'h300
	task automatic s_master();
		int n;
		wr(`TAC_A_CTRL2, 12'h043); // Idle power-down as the touch mode needs
		clr <= 1'b1;
		wr(`TAC_A_CTRL1, 12'h003);
		wait_for(4, 300, n);
		check("waits for touch", 16'(cstart), 16'h0000);
		@(posedge clk);
		touch <= 1'b1;
		expect_res(4'h3, 12'h300);
		check("touch request held", 16'(pen_n), 16'h0000);
		expect_res(4'h3, 12'h300);
		@(posedge clk);
		touch <= 1'b0;
		wait_for(4, 800, n);
		check("stops", 16'(cstart), 16'h0000);
		check("touch request idle", 16'(pen_n), 16'h0001);
		@(posedge clk);
		touch <= 1'b1;
		wait_for(4, 200, n);
		check("restarts", 16'(cstart), 16'h0001);
		@(posedge clk);
		touch <= 1'b0;
		wr(`TAC_A_CTRL1, 12'h000);
		clr <= 1'b0;
	endtask

	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Watchdog: the whole sequence needs about 63000 clocks
	initial begin
		repeat (95000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	initial begin
		n_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 12'h000;
		{wr_s, rd_s, rres, touch, clr} = 5'h00;
		hold = 1'b1;
		lat = 4'h3;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		s_regs();
		s_single();
		s_invalid();
		lat <= 4'h0;
		s_avg();
		s_hold();
		s_settle();
		s_power();
		s_seq();
		s_master();
		complete_run();
	end
endmodule
